/* File: hdl/piu_top.sv */
`default_nettype none

// Functional notes
// [RQ1] Eight priority levels arbitrate pending sources
// [RQ2] Separate fast and normal request outputs
// [RQ3] Fast request driven only by fast pin
// [RQ4] Normal request from peripherals or external pin
// [RQ5] Per-source programmable level orders competing requests
// [RQ6] Each source level or edge sensitive
// [RQ7] External polarity: rising, falling, low, high
// [RQ8] Edge pending held until serviced
module piu_top
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Request inputs
    input wire logic ext_fast_irq_input,
    input wire logic ext_irq_input_zero,
    input wire logic [piu_pkg::PIU_NUM_PERIPH-1:0] periph_irq,
    // Configuration
    input wire piu_pkg::piu_src_cfg_t fast_cfg,
    input wire piu_pkg::piu_src_cfg_t [piu_pkg::PIU_NUM_SRC-1:0] src_cfg,
    // Service
    input wire logic fast_done,
    input wire piu_pkg::piu_done_t normal_done,
    // Core side, requests active low
    output logic core_fast_irq_request_n,
    output logic core_normal_irq_request_n,
    output var piu_pkg::piu_active_t active
);
    import piu_pkg::*;

    logic fast_pend;
    logic [PIU_NUM_SRC-1:0] pend;
    logic [PIU_NUM_SRC-1:0] raw;
    wire piu_src_cfg_t [PIU_NUM_SRC-1:0] cfg_eff;
    wire [PIU_NUM_SRC-1:0] top_lvl;
    piu_active_t next_active;
    logic [PIU_NUM_SRC-1:0] pend_q;
    piu_src_cfg_t [PIU_NUM_SRC-1:0] cfg_q;

    ////////////////////////////////////////////////////////////////////////
    // Fast path: own pin, own pending, nothing else feeds it
    piu_src #(.SYNC(1'b1)) u_fast
    (
        .mclk(mclk),
        .resetn(resetn),
        .raw(ext_fast_irq_input),
        .cfg(fast_cfg),
        .clear(fast_done),
        .pending(fast_pend)
    );

    ////////////////////////////////////////////////////////////////////////
    assign raw = {periph_irq, ext_irq_input_zero};

    generate
        for (genvar i = 0; i < PIU_NUM_SRC; i++)
        begin : g_src
            localparam bit IS_EXT = (i == PIU_EXT_SRC);
            // On-chip lines are active high
            assign cfg_eff[i] = IS_EXT ? src_cfg[i] :
                {src_cfg[i].prio, src_cfg[i].edge_mode, 1'b1};
            assign top_lvl[i] = (cfg_eff[i].prio == 3'h7);
            piu_src #(.SYNC(IS_EXT)) u_src
            (
                .mclk(mclk),
                .resetn(resetn),
                .raw(raw[i]),
                .cfg(cfg_eff[i]),
                .clear(normal_done.valid &&
                    normal_done.src == PIU_SRC_W'(i)), // RQ8
                .pending(pend[i])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Highest level wins, ties go to the lowest index
    always_comb
    begin
        next_active.valid = 1'b0;
        next_active.src = PIU_SRC_RESET;
        next_active.prio = PIU_PRIO_RESET;
        for (int i = 0; i < PIU_NUM_SRC; i++)
        begin
            if (pend[i] && (!next_active.valid ||
                cfg_eff[i].prio > next_active.prio)) // RQ1 RQ5
            begin
                next_active.valid = 1'b1;
                next_active.src = PIU_SRC_W'(i);
                next_active.prio = cfg_eff[i].prio;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            active.valid <= 1'b0;
            active.src <= PIU_SRC_RESET;
            active.prio <= PIU_PRIO_RESET;
        end
        else
            active <= next_active; // RQ5
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            core_fast_irq_request_n <= 1'b1;
        else
            core_fast_irq_request_n <= ~fast_pend; // RQ2 RQ3
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            core_normal_irq_request_n <= 1'b1;
        else
            core_normal_irq_request_n <= ~(|pend); // RQ2 RQ4
    end

    ////////////////////////////////////////////////////////////////////////
    // Previous-cycle copies for the winner check
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            pend_q <= '0;
            cfg_q <= '0;
        end
        else
        begin
            pend_q <= pend;
            cfg_q <= cfg_eff;
        end
    end

    chk_fast_only: assert property (@(posedge mclk) disable iff (!resetn) // RQ3
        !core_fast_irq_request_n |-> $past(fast_pend))
        else $error("fast request without fast pin source");

    chk_fast_follow: assert property (@(posedge mclk) disable iff (!resetn) // RQ2
        fast_pend |=> !core_fast_irq_request_n)
        else $error("fast pending not presented");

    chk_normal_follow: assert property (@(posedge mclk) // RQ4
        disable iff (!resetn)
        (|pend) |=> !core_normal_irq_request_n && active.valid)
        else $error("normal pending not presented");

    chk_normal_idle: assert property (@(posedge mclk) disable iff (!resetn) // RQ4
        !(|pend) |=> core_normal_irq_request_n && !active.valid)
        else $error("normal request without source");

    chk_prio_top: assert property (@(posedge mclk) disable iff (!resetn) // RQ5
        active.valid |-> pend_q[active.src] &&
        cfg_q[active.src].prio == active.prio)
        else $error("winner level mismatch");

    chk_prio_max: assert property (@(posedge mclk) disable iff (!resetn) // RQ1
        (|(pend & top_lvl)) |=> active.prio == 3'h7)
        else $error("top level not chosen");

    cov_fast: cover property (@(posedge mclk) disable iff (!resetn)
        !core_fast_irq_request_n);
    cov_both: cover property (@(posedge mclk) disable iff (!resetn)
        !core_fast_irq_request_n && !core_normal_irq_request_n);
    cov_contend: cover property (@(posedge mclk) disable iff (!resetn)
        pend[0] && pend[1] && active.src == 5'h01);
    cov_clear: cover property (@(posedge mclk) disable iff (!resetn)
        normal_done.valid ##1 core_normal_irq_request_n);

endmodule // piu_top

`default_nettype wire

/* File: hdl/piu_pkg.sv */
`default_nettype none

package piu_pkg;

    localparam int PIU_NUM_PERIPH = 16;
    localparam int PIU_NUM_SRC = PIU_NUM_PERIPH + 1;
    localparam int PIU_EXT_SRC = 0;
    localparam int PIU_SRC_W = 5;
    localparam int PIU_PRIO_W = 3;
    localparam int PIU_NUM_LEVELS = 8;
    localparam int PIU_SYNC_STAGES = 3;
    localparam logic [PIU_PRIO_W-1:0] PIU_PRIO_RESET = 3'h0;
    localparam logic [PIU_SRC_W-1:0] PIU_SRC_RESET = 5'h00;

    // Per-source trigger setup
    typedef struct packed {
        logic [PIU_PRIO_W-1:0] prio;
        logic edge_mode;
        logic active_high;
    } piu_src_cfg_t;

    // Service acknowledge for one normal source
    typedef struct packed {
        logic valid;
        logic [PIU_SRC_W-1:0] src;
    } piu_done_t;

    // Winner presented to the core
    typedef struct packed {
        logic valid;
        logic [PIU_SRC_W-1:0] src;
        logic [PIU_PRIO_W-1:0] prio;
    } piu_active_t;

endpackage

`default_nettype wire

/* File: hdl/piu_src.sv */
`default_nettype none

module piu_src
#(
    parameter bit SYNC = 1'b1
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Source
    input wire logic raw,
    input wire piu_pkg::piu_src_cfg_t cfg,
    input wire logic clear,
    // Result
    output logic pending
);
    import piu_pkg::*;

    logic stable;
    logic settled;
    logic prev_act;
    logic lvl_act;
    logic edge_hit;

    ////////////////////////////////////////////////////////////////////////
    generate
        if (SYNC)
        begin : g_sync
            logic s1;
            logic s2;
            logic s3;
            logic held;
            logic [2:0] warm;
            logic ready;
            always_ff @(posedge mclk or negedge resetn)
            begin
                if (!resetn)
                begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    held <= 1'b0;
                    warm <= 3'h0;
                    ready <= 1'b0;
                end
                else
                begin
                    s1 <= raw;
                    s2 <= s1;
                    s3 <= s2;
                    // Ready once held first reflects the pin
                    warm <= {warm[1:0], 1'b1};
                    ready <= warm[2];
                    // Change counts once stages two and three agree
                    if (s2 == s3)
                        held <= s3;
                end
            end
            assign stable = held;
            assign settled = ready;

            chk_sync_agree: assert property (@(posedge mclk)
                disable iff (!resetn) $changed(held) |-> $past(s2 == s3))
                else $error("sync output moved without agreement");
        end
        else
        begin : g_direct
            assign stable = raw;
            assign settled = 1'b1;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Gated until the chain is filled: no false edge after reset
    assign lvl_act = settled & (cfg.active_high ? stable : ~stable); // RQ7
    assign edge_hit = lvl_act & ~prev_act;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            prev_act <= 1'b0;
        else
            prev_act <= lvl_act;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            pending <= 1'b0;
        else if (!cfg.edge_mode)
            pending <= lvl_act; // RQ6
        else if (edge_hit)
            pending <= 1'b1; // RQ8
        else if (clear)
            pending <= 1'b0; // RQ8
    end

    ////////////////////////////////////////////////////////////////////////
    chk_edge_latch: assert property (@(posedge mclk) disable iff (!resetn) // RQ8
        cfg.edge_mode && edge_hit |=> pending)
        else $error("edge did not latch pending");

    chk_edge_hold: assert property (@(posedge mclk) disable iff (!resetn) // RQ8
        cfg.edge_mode && $past(cfg.edge_mode) && pending && !clear
        |=> pending)
        else $error("edge pending dropped without clear");

    chk_level_follow: assert property (@(posedge mclk) disable iff (!resetn) // RQ6
        !cfg.edge_mode |=> pending == $past(lvl_act))
        else $error("level source does not follow input");

endmodule // piu_src

`default_nettype wire

/* File: sim/piu_core_model.sv */
`default_nettype none

module piu_core_model
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Requests seen by the core
    input wire logic fast_n,
    input wire logic normal_n,
    input wire piu_pkg::piu_active_t active,
    input wire logic ack_en,
    // Service answers
    output logic fast_done,
    output var piu_pkg::piu_done_t normal_done
);
    import piu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    int gap;

    // Hold-off lets the request drop before a second answer
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            fast_done <= 1'b0;
            normal_done <= '0;
            gap <= 0;
        end
        else
        begin
            fast_done <= 1'b0;
            normal_done <= '0;
            if (gap != 0)
                gap <= gap - 1;
            else if (ack_en && !fast_n)
            begin
                fast_done <= 1'b1;
                gap <= 4;
            end
            else if (ack_en && !normal_n && active.valid)
            begin
                normal_done <= {1'b1, active.src};
                gap <= 4;
            end
        end
    end
endmodule // piu_core_model

`default_nettype wire

/* File: sim/piu_top_bench.sv */
`default_nettype none

module piu_top_bench;
    import piu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic fast_in = 1'b0;
    logic ext_zero = 1'b0;
    logic [PIU_NUM_PERIPH-1:0] periph_irq = '0;
    piu_src_cfg_t fast_cfg = 5'h01;
    piu_src_cfg_t [PIU_NUM_SRC-1:0] src_cfg = '0;
    logic fast_done;
    piu_done_t normal_done;
    logic fast_n;
    logic normal_n;
    piu_active_t active;
    logic ack_en = 1'b0;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;

    always #2 mclk = ~mclk;

    piu_top u_piu_top (
        .mclk(mclk), .resetn(resetn), .ext_fast_irq_input(fast_in),
        .ext_irq_input_zero(ext_zero), .periph_irq(periph_irq),
        .fast_cfg(fast_cfg), .src_cfg(src_cfg), .fast_done(fast_done),
        .normal_done(normal_done), .core_fast_irq_request_n(fast_n),
        .core_normal_irq_request_n(normal_n), .active(active));

    piu_core_model u_piu_core_model (
        .mclk(mclk), .resetn(resetn), .fast_n(fast_n),
        .normal_n(normal_n), .active(active), .ack_en(ack_en),
        .fast_done(fast_done), .normal_done(normal_done));

    ////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 1000)
        begin
            mismatches++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic test_periph_edge();
        src_cfg[4] = {3'h5, 1'b1, 1'b1};
        periph_irq[3] = 1'b1;
        cyc(1);
        periph_irq[3] = 1'b0;
        cyc(2);
        check(normal_n, 1'b0);
        check(active, {1'b1, 5'h04, 3'h5});
        cyc(4);
        check(normal_n, 1'b0);
        check(fast_n, 1'b1);
        ack_en = 1'b1;
        cyc(6);
        check(normal_n, 1'b1);
        ack_en = 1'b0;
    endtask

    task automatic test_levels();
        periph_irq[2:1] = 2'h3;
        for (int p = 0; p < 8; p++)
        begin
            src_cfg[2] = {3'(p), 2'h1};
            src_cfg[3] = {3'(7 - p), 2'h1};
            cyc(3);
            check(active, p > 3 ? {1'b1, 5'h02, 3'(p)} :
                {1'b1, 5'h03, 3'(7 - p)});
        end
        src_cfg[3] = src_cfg[2];
        cyc(3);
        check(active, {1'b1, 5'h02, 3'h7});
        periph_irq[2:1] = 2'h0;
        cyc(3);
        check(normal_n, 1'b1);
    endtask

    task automatic test_ext_pin();
        logic e;
        logic h;
        for (int m = 0; m < 4; m++)
        begin
            e = m[1];
            h = m[0];
            src_cfg[0] = {3'h3, e, h};
            ext_zero = ~h;
            // Clear anything the polarity change latched
            ack_en = 1'b1;
            cyc(10);
            ack_en = 1'b0;
            check(normal_n, 1'b1);
            ext_zero = h;
            cyc(3);
            if (e)
                ext_zero = ~h;
            cyc(6);
            check(active, {1'b1, 5'h00, 3'h3});
            cyc(4);
            check(normal_n, 1'b0);
            ext_zero = ~h;
            ack_en = e;
            cyc(8);
            check(normal_n, 1'b1);
            ack_en = 1'b0;
        end
    endtask

    task automatic test_fast_pin();
        for (int e = 0; e < 2; e++)
        begin
            fast_cfg = {3'h0, e[0], 1'b1};
            fast_in = 1'b1;
            cyc(3);
            if (e)
                fast_in = 1'b0;
            cyc(6);
            check(fast_n, 1'b0);
            check(normal_n, 1'b1);
            fast_in = 1'b0;
            ack_en = 1'b1;
            cyc(8);
            check(fast_n, 1'b1);
            ack_en = 1'b0;
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        src_cfg[0] = 5'h01;
        cyc(8);
        resetn = 1'b1;
        cyc(2);
        check(fast_n, 1'b1);
        check(normal_n, 1'b1);
        test_periph_edge();
        test_levels();
        test_ext_pin();
        test_fast_pin();
        complete_run();
    end
endmodule // piu_top_bench

`default_nettype wire
